/* File: hw/irq_pkg.sv */
// shared constants and carriers for the external interrupt pin front end
package irq_pkg;

	localparam int          EXT_LINES    = 4;
	localparam int          ADDR_W       = 4;
	localparam int          EV_W         = 6;
	localparam int          PEND_W       = 5;
	localparam int          SETTLE_CYC   = 3;

	// service-vector slot codes
	localparam logic [3:0]  NUM_NMI      = 4'h1;
	localparam logic [3:0]  NUM_EXT_BASE = 4'h4;

	// register byte offsets
	localparam logic [3:0]  OFS_POLARITY = 4'h0;
	localparam logic [3:0]  OFS_STATUS   = 4'h4;
	localparam logic [3:0]  OFS_MASK     = 4'h8;
	localparam logic [3:0]  OFS_PENDING  = 4'hC;

	// event bit positions, ext lines occupy bits 3..0
	localparam int          EV_NMI       = 4;
	localparam int          EV_ACK       = 5;

	// reset values
	localparam logic [3:0]  RST_POLARITY = 4'h0;
	localparam logic [5:0]  RST_MASK     = 6'h00;
	localparam logic [3:0]  RST_ID       = 4'h0;

	typedef struct packed
	{
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
	} reg_req_t;

	typedef struct packed
	{
		logic       take;
		logic [3:0] num;
	} service_req_t;

endpackage

/* File: hw/pin_edge_sync.sv */
// three-stage pin synchroniser with settled-level edge detection
`timescale 1ns/1ns
module pin_edge_sync
	import irq_pkg::*;
#(
	parameter int WIDTH = 5
)
(
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	// asynchronous pins
	input  wire logic [WIDTH-1:0] pin,
	// settled edges, one-cycle pulses
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);

	if (WIDTH < 1)
		$error("pin_edge_sync needs at least one pin");

	typedef struct packed
	{
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
		logic [1:0]       settle;
		logic [WIDTH-1:0] rise;
		logic [WIDTH-1:0] fall;
	} sync_state_t;

	sync_state_t st;
	sync_state_t next_st;

	always_comb
	begin
		next_st      = st;
		next_st.s1   = pin;
		next_st.s2   = st.s1;
		next_st.s3   = st.s2;
		next_st.rise = '0;
		next_st.fall = '0;
		// no edges until the chain holds real pin values, so a pin high at reset is not an edge
		if (st.settle != 2'(SETTLE_CYC))
		begin
			next_st.settle = st.settle + 2'd1;
			// track the value the third stage takes at this edge, or the arming edge sees a step
			next_st.level  = st.s2;
		end
		else
		begin
			for (int i = 0; i < WIDTH; i++)
			begin
				if (st.s2[i] == st.s3[i] && st.s3[i] != st.level[i])
				begin
					next_st.level[i] = st.s3[i];
					next_st.rise[i]  = st.s3[i];
					next_st.fall[i]  = ~st.s3[i];
				end
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			st <= '0;
		else
			st <= next_st;
	end

	assign rise = st.rise;
	assign fall = st.fall;

endmodule

/* File: hw/ext_irq_front.sv */
// external interrupt pin front end: edge capture, pending, acknowledge and number
`timescale 1ns/1ns
module ext_irq_front
	import irq_pkg::*;
(
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 nrst,
	// interrupt pins
	input  wire logic                 nmi_request_line,
	input  wire logic                 ext_request_line_0,
	input  wire logic                 ext_request_line_1,
	input  wire logic                 ext_request_line_2,
	input  wire logic                 ext_request_line_3,
	// register port
	input  wire reg_req_t             reg_req,
	output logic      [31:0]          reg_rdata,
	// processor service handshake
	input  wire service_req_t         service_req,
	output logic                      nmi_pending,
	output logic      [EXT_LINES-1:0] ext_pending,
	// acknowledge pins
	output logic                      service_ack_strobe,
	output logic                      service_id_bit3,
	output logic                      service_id_bit2,
	output logic                      service_id_bit1,
	output logic                      service_id_bit0,
	// event interrupt
	output logic                      irq
);

	////////////////////////////////////////////////////////////////////////////////

	typedef struct packed
	{
		logic [EXT_LINES-1:0] ext_request_polarity_bits;
		logic [EV_W-1:0]      status;
		logic [EV_W-1:0]      mask;
		logic                 nmi_pending;
		logic [EXT_LINES-1:0] ext_pending;
		logic                 ack;
		logic [3:0]           id;
		logic [31:0]          rdata;
		logic                 irq;
	} front_state_t;

	front_state_t st;
	front_state_t next_st;

	logic [PEND_W-1:0] pin_rise;
	logic [PEND_W-1:0] pin_fall;

	function automatic logic [3:0] ext_slot(input int line);
		ext_slot = NUM_EXT_BASE + 4'(line);
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
		hit = (addr == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	// bit 4 is the nonmaskable pin, bits 3..0 the external lines
	pin_edge_sync #(
		.WIDTH (PEND_W)
	) u_sync (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.pin     ({nmi_request_line, ext_request_line_3, ext_request_line_2,
		           ext_request_line_1, ext_request_line_0}),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		logic [EXT_LINES-1:0] ext_edge;
		logic                 nmi_edge;
		logic [EV_W-1:0]      events;
		logic [EV_W-1:0]      cleared;

		next_st       = st;
		ext_edge      = '0;
		nmi_edge      = pin_rise[EV_NMI];
		events        = '0;
		cleared       = st.status;
		next_st.ack   = 1'b0;
		next_st.rdata = '0;

		// polarity bit low picks rising, high picks falling
		for (int i = 0; i < EXT_LINES; i++)
			ext_edge[i] = st.ext_request_polarity_bits[i] ? pin_fall[i] : pin_rise[i];

		// service clears first so a fresh edge in the same cycle stays pending
		if (service_req.take)
		begin
			next_st.ack = 1'b1;
			next_st.id  = service_req.num;
			if (service_req.num == NUM_NMI)
				next_st.nmi_pending = 1'b0;
			for (int i = 0; i < EXT_LINES; i++)
				if (service_req.num == ext_slot(i))
					next_st.ext_pending[i] = 1'b0;
		end
		if (nmi_edge)
			next_st.nmi_pending = 1'b1;
		next_st.ext_pending = next_st.ext_pending | ext_edge;

		events[EXT_LINES-1:0] = ext_edge;
		events[EV_NMI]        = nmi_edge;
		events[EV_ACK]        = service_req.take;

		if (reg_req.wr)
		begin
			if (hit(reg_req.addr, OFS_POLARITY))
				next_st.ext_request_polarity_bits = reg_req.wdata[EXT_LINES-1:0];
			if (hit(reg_req.addr, OFS_STATUS))
				cleared = st.status & ~reg_req.wdata[EV_W-1:0];
			if (hit(reg_req.addr, OFS_MASK))
				next_st.mask = reg_req.wdata[EV_W-1:0];
		end
		// set wins over a write-one clear in the same cycle
		next_st.status = cleared | events;
		next_st.irq    = |(next_st.status & next_st.mask);

		if (reg_req.rd)
		begin
			unique case (reg_req.addr)
				OFS_POLARITY: next_st.rdata[EXT_LINES-1:0] = st.ext_request_polarity_bits;
				OFS_STATUS:   next_st.rdata[EV_W-1:0]      = st.status;
				OFS_MASK:     next_st.rdata[EV_W-1:0]      = st.mask;
				OFS_PENDING:  next_st.rdata[PEND_W-1:0]    = {st.nmi_pending, st.ext_pending};
				default:      next_st.rdata                = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			st                           <= '0;
			st.ext_request_polarity_bits <= RST_POLARITY;
			st.mask                      <= RST_MASK;
			st.id                        <= RST_ID;
		end
		else
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////////////

	assign reg_rdata          = st.rdata;
	assign nmi_pending        = st.nmi_pending;
	assign ext_pending        = st.ext_pending;
	assign service_ack_strobe = st.ack;
	assign service_id_bit3    = st.id[3];
	assign service_id_bit2    = st.id[2];
	assign service_id_bit1    = st.id[1];
	assign service_id_bit0    = st.id[0];
	assign irq                = st.irq;

endmodule

/* File: bench/irq_src_model.sv */
// board interrupt sources driving the request pins
`timescale 1ns/1ns
module irq_src_model
(
	// clock
	input  wire logic       ref_clk,
	// commanded levels and pins {nmi, ext3..ext0}
	input  wire logic [4:0] want,
	output logic      [4:0] pins
);
	// levels move only on the clock and then hold for many cycles
	always_ff @(posedge ref_clk)
		pins <= want;
endmodule

/* File: bench/ext_irq_front_asserts.sv */
// port-level timing checks of the interrupt front end
`timescale 1ns/1ns
module ext_irq_front_asserts
	import irq_pkg::*;
(
	// clock and reset
	input wire logic           ref_clk,
	input wire logic           nrst,
	// pins
	input wire logic           nmi_request_line,
	input wire logic           ext_request_line_0,
	// service side
	input wire service_req_t   service_req,
	input wire logic           nmi_pending,
	input wire logic [3:0]     ext_pending,
	input wire logic           service_ack_strobe,
	input wire logic           service_id_bit3,
	input wire logic           service_id_bit2,
	input wire logic           service_id_bit1,
	input wire logic           service_id_bit0
);
	logic [3:0] id;
	assign id = {service_id_bit3, service_id_bit2, service_id_bit1, service_id_bit0};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence s_ack;
		service_ack_strobe && id == $past(service_req.num);
	endsequence
	a_ack_on_take: assert property (service_req.take |=> s_ack)
		else $error("no acknowledge with number");
	a_ack_cause: assert property (service_ack_strobe |-> $past(service_req.take))
		else $error("acknowledge without service");
	a_id_holds: assert property (!service_req.take |=> $stable(id))
		else $error("number moved without service");
	// edge, not level: pin low well before it was seen high
	a_nmi_edge: assert property ($rose(nmi_pending) |->
		$past(nmi_request_line, 3) && !$past(nmi_request_line, 6))
		else $error("nonmaskable pending without rising edge");
	a_ext_edge: assert property ($rose(ext_pending[0]) |->
		$past(ext_request_line_0, 3) != $past(ext_request_line_0, 6))
		else $error("line pending without edge");
	a_nmi_held: assert property ($fell(nmi_pending) |->
		$past(service_req.take) && $past(service_req.num) == NUM_NMI)
		else $error("nonmaskable pending dropped without service");
endmodule
bind ext_irq_front ext_irq_front_asserts chk (.ref_clk, .nrst, .nmi_request_line,
	.ext_request_line_0, .service_req, .nmi_pending, .ext_pending, .service_ack_strobe,
	.service_id_bit3, .service_id_bit2, .service_id_bit1, .service_id_bit0);

/* File: bench/test_ext_irq_front.sv */
// self-checking bench of the interrupt pin front end
`timescale 1ns/1ns
module test_ext_irq_front
	import irq_pkg::*;
;
	logic         ref_clk = 0;
	logic         nrst = 0;
	logic [4:0]   want = 5'h00;
	logic [4:0]   pins;
	reg_req_t     reg_req = '0;
	service_req_t service_req = '0;
	logic [31:0]  reg_rdata;
	logic         nmi_pending, service_ack_strobe, irq;
	logic [3:0]   ext_pending, id;
	int           bad_count = 0;
	int           check_count = 0;
	irq_src_model src (.ref_clk, .want, .pins);
	ext_irq_front dut (.ref_clk, .nrst, .nmi_request_line(pins[4]),
		.ext_request_line_0(pins[0]), .ext_request_line_1(pins[1]),
		.ext_request_line_2(pins[2]), .ext_request_line_3(pins[3]),
		.reg_req, .reg_rdata, .service_req, .nmi_pending, .ext_pending,
		.service_ack_strobe, .service_id_bit3(id[3]), .service_id_bit2(id[2]),
		.service_id_bit1(id[1]), .service_id_bit0(id[0]), .irq);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge ref_clk) reg_req <= '{1'b0, 1'b1, a, 32'h0000_0000};
		@(posedge ref_clk) reg_req.rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk) reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge ref_clk) reg_req.wr <= 1'b0;
	endtask
	task automatic svc(input logic [3:0] n);
		@(posedge ref_clk) service_req <= '{1'b1, n};
		@(posedge ref_clk) service_req.take <= 1'b0;
		#1 chk(service_ack_strobe, 1);
		chk(id, n);
	endtask
	// pin change, then long enough for sync and capture
	task automatic pin(input int b, input logic v);
		@(posedge ref_clk) want[b] <= v;
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
		forever #25 ref_clk = ~ref_clk;
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		bad_count++;
		finish_test;
	end
	initial
	begin
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd(OFS_POLARITY, 0);
		rd(4'h1, 0);
		wr(OFS_MASK, 32'h0000_003F);
		pin(4, 1);
		chk(nmi_pending, 1);
		chk(irq, 1);
		svc(NUM_NMI);
		pin(4, 1);
		chk(nmi_pending, 0);
		pin(4, 0);
		chk(nmi_pending, 0);
		wr(OFS_POLARITY, 32'h0000_0005);
		for (int i = 0; i < 4; i++)
		begin
			pin(i, 1);
			chk(ext_pending[i], i % 2);
			pin(i, 0);
			chk(ext_pending[i], 1);
			svc(NUM_EXT_BASE + 4'(i));
			chk(ext_pending[i], 0);
		end
		// internal source, not a pin
		svc(4'hE);
		@(posedge ref_clk);
		#1 chk(service_ack_strobe, 0);
		chk(id, 4'hE);
		wr(OFS_MASK, 0);
		repeat (2) @(posedge ref_clk);
		#1 chk(irq, 0);
		rd(OFS_STATUS, 32'h0000_003F);
		wr(OFS_STATUS, 32'h0000_003F);
		rd(OFS_STATUS, 0);
		rd(OFS_PENDING, 0);
		finish_test;
	end
endmodule
